/* File: hw/dil_loader.sv */
// Word FIFO and the top of the six-channel input loader.
//
// What this block does
// - Input word is ten bits, bit 9 MSB.
// - Edge select high: rising edge, low: falling.
// - One word per active edge into successive channels.
// - Direction low starts channel 0, high channel 5.
// - Rising mode: start seen on previous rising edge.
// - Falling mode: start seen on previous falling edge.
// - Transfer on rising edge updates outputs next fall.
// - Standby high debiases, power to minimum.
// - Polarity high: outputs above midpoint, else below.
// - Each start opens six-edge, six-word loading cycle.
// - Standby discards channel and output data.
`timescale 1ns/1ns

module dil_fifo #(
    parameter int WIDTH = dil_pkg::ENTRY_W,
    parameter int DEPTH = dil_pkg::FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0]    cnt_q, cnt_d;
    logic             rdy_q, rdy_d, vld_q, vld_d;
    logic             push, pop;

    assign in_ready  = rdy_q;
    assign out_valid = vld_q;
    assign out_data  = mem[rd_q];

    // Pointer and fill count update; flush empties the buffer.
    always_comb begin
        push  = in_valid && rdy_q;
        pop   = vld_q && out_ready;
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            wr_d = (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
        if (flush) begin
            wr_d  = '0;
            rd_d  = '0;
            cnt_d = '0;
        end
        rdy_d = (cnt_d != CNT_FULL);
        vld_d = (cnt_d != '0);
    end

    // Registers of the buffer control.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
            vld_q <= 1'b0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
            vld_q <= vld_d;
        end
    end

    // Storage array, written on an accepted push.
    always_ff @(posedge clk) begin
        if (push && !flush) begin
            mem[wr_q] <= in_data;
        end
    end

endmodule : dil_fifo

module dil_loader (
    input  wire logic                        CLK,
    input  wire logic                        RESETN,
    input  wire logic                        PIXEL_CLOCK,
    input  wire logic [dil_pkg::WORD_W-1:0]  INPUT_WORD_BUS,
    input  wire logic                        EDGE_SELECT,
    input  wire logic                        DIRECTION_SELECT,
    input  wire logic                        SEQUENCE_START,
    input  wire logic                        OUTPUT_TRANSFER,
    input  wire logic                        POLARITY_INVERT,
    input  wire logic                        LOW_POWER_HOLD,
    output dil_pkg::dil_chan_bus_t           CHANNEL_OUTPUT,
    output logic                             OUTPUT_ABOVE_MID,
    output logic                             STANDBY_ACTIVE,
    output logic                             INPUT_READY
);

    // ************************************************************
    // State.
    // ************************************************************
    logic                          pclk_q, pclk_d;
    logic                          start_q, start_d;
    logic [dil_pkg::CNT_W-1:0]     rest_q, rest_d;
    logic                          xfr_q, xfr_d;
    logic [dil_pkg::IDX_W-1:0]     idx_q, idx_d;
    dil_pkg::dil_chan_bus_t        chan_q, chan_d;
    dil_pkg::dil_chan_bus_t        out_q, out_d;
    logic                          pol_q, pol_d;
    logic                          hold_q, hold_d;
    logic                          rise, fall, active;
    logic                          in_valid, fifo_ready;
    logic                          out_valid, pop;
    dil_pkg::dil_entry_t           in_ent, out_ent;
    logic [dil_pkg::ENTRY_W-1:0]   out_raw;

    assign CHANNEL_OUTPUT   = out_q;
    assign OUTPUT_ABOVE_MID = pol_q;
    assign STANDBY_ACTIVE   = hold_q;
    assign INPUT_READY      = fifo_ready;
    assign out_ent          = dil_pkg::dil_entry_t'(out_raw);

    // ************************************************************
    // Capture of words on the active panel clock edge.
    // ************************************************************
    // Edge detect, start tracking and the six-word window.
    always_comb begin
        pclk_d   = PIXEL_CLOCK;
        rise     = PIXEL_CLOCK && !pclk_q;
        fall     = !PIXEL_CLOCK && pclk_q;
        active   = EDGE_SELECT ? rise : fall;
        start_d  = start_q;
        rest_d   = rest_q;
        in_valid = 1'b0;
        in_ent.word       = INPUT_WORD_BUS;
        in_ent.first      = start_q;
        in_ent.from_right = DIRECTION_SELECT;
        if (active) begin
            start_d = SEQUENCE_START;
            if (start_q) begin
                in_valid = 1'b1;
                rest_d   = dil_pkg::SEQ_REST;
            end else if (rest_q != '0) begin
                in_valid = 1'b1;
                rest_d   = rest_q - 1'b1;
            end
        end
        // Words past the sixth are simply never pushed.
        if (hold_q) begin
            start_d  = 1'b0;
            rest_d   = '0;
            in_valid = 1'b0;
        end
    end

    dil_fifo #(
        .WIDTH (dil_pkg::ENTRY_W),
        .DEPTH (dil_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK),
        .rst_n     (RESETN),
        .flush     (hold_q),
        .in_valid  (in_valid),
        .in_data   (in_ent),
        .in_ready  (fifo_ready),
        .out_valid (out_valid),
        .out_data  (out_raw),
        .out_ready (!hold_q)
    );

    // ************************************************************
    // Channel registers, output transfer and standby.
    // ************************************************************
    // Drain one word per cycle into the addressed channel register.
    always_comb begin
        pop    = out_valid && !hold_q;
        idx_d  = idx_q;
        chan_d = chan_q;
        out_d  = out_q;
        xfr_d  = xfr_q;
        pol_d  = POLARITY_INVERT;
        hold_d = LOW_POWER_HOLD;
        if (pop) begin
            if (out_ent.first) begin
                idx_d = out_ent.from_right ? dil_pkg::CH_RIGHT
                                           : dil_pkg::CH_LEFT;
            end else if (out_ent.from_right) begin
                idx_d = (idx_q == dil_pkg::CH_LEFT) ? idx_q
                                                    : idx_q - 1'b1;
            end else begin
                idx_d = (idx_q == dil_pkg::CH_RIGHT) ? idx_q
                                                     : idx_q + 1'b1;
            end
            chan_d[idx_d] = out_ent.word;
        end
        if (rise && OUTPUT_TRANSFER) begin
            xfr_d = 1'b1;
        end else if (fall && xfr_q) begin
            xfr_d = 1'b0;
            out_d = chan_q;
        end
        if (hold_q) begin
            chan_d = '0;
            out_d  = '0;
            xfr_d  = 1'b0;
            idx_d  = dil_pkg::CH_LEFT;
        end
    end

    // Registers of the loader.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pclk_q  <= 1'b0;
            start_q <= 1'b0;
            rest_q  <= '0;
            xfr_q   <= 1'b0;
            idx_q   <= dil_pkg::CH_LEFT;
            chan_q  <= '0;
            out_q   <= '0;
            pol_q   <= 1'b0;
            hold_q  <= 1'b0;
        end else begin
            pclk_q  <= pclk_d;
            start_q <= start_d;
            rest_q  <= rest_d;
            xfr_q   <= xfr_d;
            idx_q   <= idx_d;
            chan_q  <= chan_d;
            out_q   <= out_d;
            pol_q   <= pol_d;
            hold_q  <= hold_d;
        end
    end

endmodule : dil_loader

/* File: hw/dil_pkg.sv */
// Shared constants and types of the six-channel input loader.
package dil_pkg;

    // ************************************************************
    // Widths, counts and reset values.
    // ************************************************************
    localparam int WORD_W     = 10;
    localparam int NUM_CH     = 6;
    localparam int SEQ_LEN    = 6;
    localparam int FIFO_DEPTH = 16;
    localparam int IDX_W      = 3;
    localparam int CNT_W      = 3;
    localparam logic [IDX_W-1:0]  CH_LEFT  = 3'h0;
    localparam logic [IDX_W-1:0]  CH_RIGHT = 3'h5;
    localparam logic [CNT_W-1:0]  SEQ_REST = 3'h5;
    localparam logic [WORD_W-1:0] CODE_RST = 10'h000;

    // ************************************************************
    // Types.
    // ************************************************************
    typedef logic [NUM_CH-1:0][WORD_W-1:0] dil_chan_bus_t;

    // One captured word with its place in the sequence.
    typedef struct packed {
        logic [WORD_W-1:0] word;
        logic              first;
        logic              from_right;
    } dil_entry_t;

    localparam int ENTRY_W = $bits(dil_entry_t);

endpackage : dil_pkg

/* File: testbench/dil_loader_sva.sv */
// Port checker of the six-channel input loader.
`timescale 1ns/1ns

module dil_loader_sva (
    input wire logic                   CLK,
    input wire logic                   RESETN,
    input wire logic                   PIXEL_CLOCK,
    input wire logic                   POLARITY_INVERT,
    input wire logic                   LOW_POWER_HOLD,
    input wire dil_pkg::dil_chan_bus_t CHANNEL_OUTPUT,
    input wire logic                   OUTPUT_ABOVE_MID,
    input wire logic                   STANDBY_ACTIVE,
    input wire logic                   INPUT_READY
);
    logic pc_q;
    logic fall;

    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    // Old panel clock copy, so falling panel edges can be seen.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pc_q <= 1'b0;
        end else begin
            pc_q <= PIXEL_CLOCK;
        end
    end
    assign fall = pc_q & ~PIXEL_CLOCK;

    // ************************************************************
    // Assertions.
    // ************************************************************
    a_pol_high: assert property (POLARITY_INVERT |=> OUTPUT_ABOVE_MID)
        else $error("region not above midpoint");
    a_pol_low: assert property (!POLARITY_INVERT |=> !OUTPUT_ABOVE_MID)
        else $error("region not below midpoint");
    a_low_power_hold_on: assert property (LOW_POWER_HOLD |=> STANDBY_ACTIVE)
        else $error("standby not entered");
    a_low_power_hold_off: assert property (!LOW_POWER_HOLD |=> !STANDBY_ACTIVE)
        else $error("standby not left");
    a_low_power_hold_clear: assert property (
        STANDBY_ACTIVE |=> CHANNEL_OUTPUT == '0)
        else $error("outputs kept in standby");
    a_low_power_hold_exit: assert property (
        $fell(STANDBY_ACTIVE) |-> CHANNEL_OUTPUT == '0)
        else $error("outputs not zero after standby");
    a_out_cause: assert property ($changed(CHANNEL_OUTPUT) |->
        $past(fall) || $past(fall, 2) || $past(STANDBY_ACTIVE))
        else $error("outputs changed without transfer");
    a_ready_kept: assert property (INPUT_READY)
        else $error("word queue full");

    cover property ($changed(CHANNEL_OUTPUT) && !STANDBY_ACTIVE);
    cover property ($rose(STANDBY_ACTIVE));
    cover property ($rose(OUTPUT_ABOVE_MID));
endmodule : dil_loader_sva

bind dil_loader dil_loader_sva chk (.CLK(CLK), .RESETN(RESETN),
    .PIXEL_CLOCK(PIXEL_CLOCK), .POLARITY_INVERT(POLARITY_INVERT),
    .LOW_POWER_HOLD(LOW_POWER_HOLD), .CHANNEL_OUTPUT(CHANNEL_OUTPUT),
    .OUTPUT_ABOVE_MID(OUTPUT_ABOVE_MID), .STANDBY_ACTIVE(STANDBY_ACTIVE),
    .INPUT_READY(INPUT_READY));

/* File: testbench/dil_panel_model.sv */
// Image processor model that feeds panel lines to the loader.
`timescale 1ns/1ns

module dil_panel_model (
    input  wire logic       clk,
    output logic            pixel_clock,
    output logic [9:0]      word,
    output logic            start,
    output logic            output_transfer
);
    // Idle levels at time zero.
    initial begin
        pixel_clock = 1'b0;
        word = 10'h000;
        start = 1'b0;
        output_transfer = 1'b0;
    end

    // One panel half; words outside the six slots change every half.
    task automatic half(input logic lvl, input logic act, input int i,
                        input logic [9:0] base);
        pixel_clock <= lvl;
        start <= act && i == 0;
        word <= (act && i > 0 && i < 7) ? base + 10'(i - 1) : ~word;
        output_transfer <= lvl && i == 7;
        repeat (4) @(posedge clk);
    endtask : half

    // Start, six words, a stray seventh word, then a transfer.
    task automatic frame(input logic rise, input logic [9:0] base);
        for (int i = 0; i < 9; i++) begin
            half(1'b1, rise, i, base);
            half(1'b0, !rise, i, base);
        end
    endtask : frame
endmodule : dil_panel_model

/* File: testbench/dil_loader_tb.sv */
// Self-checking testbench of the six-channel input loader.
`timescale 1ns/1ns

`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("[ERR] %0t got %h want %h", $time, got, exp); \
    end \
end

module dil_loader_tb;
    logic                   CLK;
    logic                   RESETN;
    logic                   pclk, start, output_transfer;
    logic [9:0]             word;
    logic                   edge_sel, dir, pol, hold;
    dil_pkg::dil_chan_bus_t chan;
    logic                   above, low_power_hold, ready;
    int                     err_count;
    int                     samples_checked;

    dil_loader uut (.CLK(CLK), .RESETN(RESETN), .PIXEL_CLOCK(pclk),
        .INPUT_WORD_BUS(word), .EDGE_SELECT(edge_sel),
        .DIRECTION_SELECT(dir), .SEQUENCE_START(start),
        .OUTPUT_TRANSFER(output_transfer), .POLARITY_INVERT(pol),
        .LOW_POWER_HOLD(hold), .CHANNEL_OUTPUT(chan),
        .OUTPUT_ABOVE_MID(above), .STANDBY_ACTIVE(low_power_hold),
        .INPUT_READY(ready));
    dil_panel_model proc (.clk(CLK), .pixel_clock(pclk), .word(word),
        .start(start), .output_transfer(output_transfer));

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    // Loads one line and checks each channel after the transfer.
    task automatic t_load(input logic rise, input logic d,
                          input logic [9:0] base);
        @(posedge CLK);
        edge_sel <= rise;
        dir <= d;
        proc.frame(rise, base);
        @(negedge CLK);
        for (int k = 0; k < dil_pkg::NUM_CH; k++) begin
            `CHK(chan[k], base + 10'(d ? 5 - k : k))
        end
        `CHK(ready, 1'b1)
    endtask : t_load

    // Polarity follows its input; standby wipes and holds the outputs.
    task automatic t_modes();
        for (int p = 1; p >= 0; p--) begin
            @(posedge CLK);
            pol <= p[0];
            hold <= p[0];
            repeat (3) @(posedge CLK);
            @(negedge CLK);
            `CHK(above, p[0])
            `CHK(low_power_hold, p[0])
            `CHK(chan, '0)
        end
    endtask : t_modes

    // Free-running system clock.
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    // Cuts a hung run short.
    initial begin
        repeat (3000) @(posedge CLK);
        err_count++;
        summarize();
    end

    // Reset, then every scenario in turn.
    initial begin
        err_count = 0;
        samples_checked = 0;
        RESETN = 1'b0;
        edge_sel = 1'b1;
        dir = 1'b0;
        pol = 1'b0;
        hold = 1'b0;
        repeat (3) @(posedge CLK);
        RESETN <= 1'b1;
        repeat (2) @(posedge CLK);
        t_load(1'b1, 1'b0, 10'h100);
        t_load(1'b1, 1'b1, 10'h2F0);
        t_load(1'b0, 1'b0, 10'h3FA);
        t_load(1'b0, 1'b1, 10'h055);
        t_modes();
        t_load(1'b1, 1'b0, 10'h200);
        summarize();
    end
endmodule : dil_loader_tb
